/* rtl/ibs_pkg.sv */
// Package for the instruction bus-cycle sequencer: operation codes, cycle kinds, counts
// Assumes a single core clock and a bus that takes one cycle per state when granted
package ibs_pkg;

    // ****************************************
    // Operation selectors
    // ****************************************
    typedef enum logic [4:0] {
        IBS_BIT_STORE_ABS32  = 5'h00, // Bit store to 32-bit absolute address
        IBS_BIT_TEST_IND     = 5'h01, // Bit test on register-indirect operand
        IBS_BIT_XOR_ABS32    = 5'h02, // Bit exclusive-or at 32-bit absolute address
        IBS_SDIV_BYTE        = 5'h03, // Signed divide, byte form
        IBS_SDIV_WORD        = 5'h04, // Signed divide, word form
        IBS_UDIV_BYTE        = 5'h05, // Unsigned divide, byte form
        IBS_UDIV_WORD        = 5'h06, // Unsigned divide, word form
        IBS_BLOCK_MOVE       = 5'h07, // Block move of n bytes
        IBS_JUMP_MEM_IND     = 5'h08, // Memory-indirect jump
        IBS_CALL_REG_IND     = 5'h09, // Register-indirect subroutine call
        IBS_CALL_MEM_IND     = 5'h0a, // Memory-indirect subroutine call
        IBS_JUMP_ABS24       = 5'h0b, // Jump to 24-bit absolute
        IBS_CALL_REL16       = 5'h0c, // Relative call, 16-bit displacement
        IBS_LDCTL_POSTINC    = 5'h0d, // Load control register, post-increment
        IBS_LDCTL_DISP32     = 5'h0e, // Load control register, 32-bit displacement
        IBS_MULTI_POP        = 5'h0f, // Multiple-register pop
        IBS_CMP_LONG_IMM     = 5'h10, // Long compare with 32-bit immediate
        IBS_CMP_LONG_REG     = 5'h11, // Long compare register to register
        IBS_CLEAR_ACC        = 5'h12  // Accumulator operation, not supported
    } ibs_op_e;

    // ****************************************
    // Cycle kinds and step encoding
    // ****************************************
    // Step word: {last, lock, kind[2:0]}
    localparam logic [2:0] IBS_K_FETCH = 3'h0; // Read word, instruction stream
    localparam logic [2:0] IBS_K_RDB = 3'h1; // Read byte operand
    localparam logic [2:0] IBS_K_RDW = 3'h2; // Read word operand or vector
    localparam logic [2:0] IBS_K_WRB = 3'h3; // Write byte operand
    localparam logic [2:0] IBS_K_WRW = 3'h4; // Write word (stack)
    localparam logic [2:0] IBS_K_IDLE = 3'h5; // Internal state, no bus
    localparam logic [2:0] IBS_K_LOOP = 3'h6; // Repeat marker (block move / pop)
    localparam int IBS_LOCK_BIT = 3;
    localparam int IBS_LAST_BIT = 4;
    localparam int IBS_MAX_STEPS = 8;

    // ****************************************
    // Timing counts in core clock states
    // ****************************************
    localparam logic [4:0] IBS_DIV_BYTE_STATES = 5'h0b; // 11 states
    localparam logic [4:0] IBS_DIV_WORD_STATES = 5'h13; // 19 states

endpackage

/* rtl/ibs_sequencer.sv */
// Bus-cycle sequencer: turns one instruction form into an ordered list of bus cycles
// Assumes the internal bus grants every request; lock is held across the next cycle
//
// Notes on behaviour
// - bit store abs32: three fetches, locked RMW
// - bit test indirect: fetch, byte read, locked fetch
// - bit xor abs32: three fetches, read, locked fetch
// - signed divide: two fetches, 11/19 idle
// - unsigned divide: one fetch, 11/19 idle
// - block move: pair reads, then n copies
// - indirect jump: vector read(s), idle, target
// - register call: target fetch, then push(es)
// - indirect call: vectors, pushes, then target
// - abs24 jump: fetch, one idle, target
// - relative call: fetch, idle, target, push(es)
// - post-increment control load: idle then read
// - displacement control load: five fetches, read
// - multi pop: locked fetch, idle, pairs
// - long compare immediate fetches two extra
`timescale 1ns/1ps
`default_nettype none

module ibs_sequencer
    import ibs_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Instruction request
    input wire logic START,
    input wire logic [4:0] OP,
    input wire logic ADVANCED,
    input wire logic [7:0] COUNT,
    // Bus cycle outputs
    output logic BUS_REQ,
    output logic BUS_WRITE,
    output logic BUS_BYTE,
    output logic BUS_LOCK,
    output logic [2:0] BUS_KIND,
    // Status
    output logic BUSY,
    output logic DONE,
    output logic UNSUPPORTED
);

    // ****************************************
    // State
    // ****************************************
    typedef enum logic [2:0] {
        IBS_IDLE = 3'b001, // Waiting for an instruction
        IBS_RUN = 3'b010,  // Walking the step list
        IBS_WAIT = 3'b100  // Counting internal states
    } ibs_state_e;

    typedef struct packed {
        ibs_state_e st;     // Sequencer state
        logic [4:0] op;     // Latched operation
        logic adv;          // Latched advanced mode
        logic [7:0] reps;   // Remaining repetitions
        logic [2:0] idx;    // Step index
        logic [4:0] wait_n; // Internal states left
        logic loop_ph;      // Phase inside a repeated pair
        logic req;          // Registered outputs follow
        logic wr;
        logic byt;
        logic lck;
        logic [2:0] kind;
        logic done;
        logic unsup;
        logic busy;         // Sequencer occupied, registered so the port leaves a flip-flop
    } ibs_s;

    ibs_s cur; // Registered state
    ibs_s next_cur; // Next state

    // Build a step word
    function automatic logic [4:0] stp(input logic last, input logic lock, input logic [2:0] k);
        stp = {last, lock, k};
    endfunction

    // Step table per operation, mode and index
    function automatic logic [4:0] step(input logic [4:0] op, input logic adv, input logic [2:0] i);
        logic [4:0] s;
        s = stp(1'b1, 1'b0, IBS_K_FETCH);
        unique case (op)
            IBS_BIT_STORE_ABS32: case (i)
                3'd0, 3'd1, 3'd2: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                3'd3: s = stp(1'b0, 1'b1, IBS_K_RDB);
                3'd4: s = stp(1'b0, 1'b1, IBS_K_FETCH);
                default: s = stp(1'b1, 1'b0, IBS_K_WRB);
            endcase
            IBS_BIT_TEST_IND: case (i)
                3'd0: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                3'd1: s = stp(1'b0, 1'b0, IBS_K_RDB);
                default: s = stp(1'b1, 1'b1, IBS_K_FETCH);
            endcase
            IBS_BIT_XOR_ABS32: case (i)
                3'd0, 3'd1, 3'd2: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                3'd3: s = stp(1'b0, 1'b0, IBS_K_RDB);
                default: s = stp(1'b1, 1'b1, IBS_K_FETCH);
            endcase
            IBS_SDIV_BYTE, IBS_SDIV_WORD: case (i)
                3'd0, 3'd1: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                default: s = stp(1'b1, 1'b0, IBS_K_IDLE);
            endcase
            IBS_UDIV_BYTE, IBS_UDIV_WORD: case (i)
                3'd0: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                default: s = stp(1'b1, 1'b0, IBS_K_IDLE);
            endcase
            IBS_BLOCK_MOVE: case (i)
                3'd0: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                3'd1, 3'd2: s = stp(1'b0, 1'b0, IBS_K_RDB);
                3'd3: s = stp(1'b0, 1'b0, IBS_K_LOOP);
                default: s = stp(1'b1, 1'b0, IBS_K_FETCH);
            endcase
            IBS_JUMP_MEM_IND: case (i)
                3'd0: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                3'd1: s = stp(1'b0, adv, IBS_K_RDW);
                3'd2: s = adv ? stp(1'b0, 1'b0, IBS_K_RDW) : stp(1'b0, 1'b0, IBS_K_IDLE);
                3'd3: s = adv ? stp(1'b0, 1'b0, IBS_K_IDLE) : stp(1'b1, 1'b0, IBS_K_FETCH);
                default: s = stp(1'b1, 1'b0, IBS_K_FETCH);
            endcase
            IBS_CALL_REG_IND: case (i)
                3'd0, 3'd1: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                3'd2: s = stp(~adv, adv, IBS_K_WRW);
                default: s = stp(1'b1, 1'b0, IBS_K_WRW);
            endcase
            IBS_CALL_MEM_IND: case (i)
                3'd0: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                3'd1: s = stp(1'b0, adv, IBS_K_RDW);
                3'd2: s = adv ? stp(1'b0, 1'b0, IBS_K_RDW) : stp(1'b0, 1'b0, IBS_K_WRW);
                3'd3: s = adv ? stp(1'b0, 1'b1, IBS_K_WRW) : stp(1'b1, 1'b0, IBS_K_FETCH);
                3'd4: s = stp(1'b0, 1'b0, IBS_K_WRW);
                default: s = stp(1'b1, 1'b0, IBS_K_FETCH);
            endcase
            IBS_JUMP_ABS24: case (i)
                3'd0: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                3'd1: s = stp(1'b0, 1'b0, IBS_K_IDLE);
                default: s = stp(1'b1, 1'b0, IBS_K_FETCH);
            endcase
            IBS_CALL_REL16: case (i)
                3'd0: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                3'd1: s = stp(1'b0, 1'b0, IBS_K_IDLE);
                3'd2: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                3'd3: s = stp(~adv, adv, IBS_K_WRW);
                default: s = stp(1'b1, 1'b0, IBS_K_WRW);
            endcase
            IBS_LDCTL_POSTINC: case (i)
                3'd0, 3'd1: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                3'd2: s = stp(1'b0, 1'b0, IBS_K_IDLE);
                default: s = stp(1'b1, 1'b0, IBS_K_RDW);
            endcase
            IBS_LDCTL_DISP32: case (i)
                3'd0, 3'd1, 3'd2, 3'd3, 3'd4: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                default: s = stp(1'b1, 1'b0, IBS_K_RDW);
            endcase
            IBS_MULTI_POP: case (i)
                3'd0: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                3'd1: s = stp(1'b0, 1'b1, IBS_K_FETCH);
                3'd2: s = stp(1'b0, 1'b0, IBS_K_IDLE);
                default: s = stp(1'b1, 1'b0, IBS_K_LOOP);
            endcase
            IBS_CMP_LONG_IMM: case (i)
                3'd0, 3'd1: s = stp(1'b0, 1'b0, IBS_K_FETCH);
                default: s = stp(1'b1, 1'b0, IBS_K_FETCH);
            endcase
            default: s = stp(1'b1, 1'b0, IBS_K_FETCH); // Register compare: one fetch
        endcase
        step = s;
    endfunction

    logic [4:0] cur_step; // Step word at current index
    assign cur_step = step(cur.op, cur.adv, cur.idx);

    logic [4:0] after_loop; // Step word that follows a repeat marker
    assign after_loop = step(cur.op, cur.adv, cur.idx + 3'd1);

    // Cycle kinds that write
    function automatic logic is_write(input logic [2:0] k);
        is_write = (k == IBS_K_WRB) || (k == IBS_K_WRW);
    endfunction

    // Cycle kinds that move a byte
    function automatic logic is_byte(input logic [2:0] k);
        is_byte = (k == IBS_K_RDB) || (k == IBS_K_WRB);
    endfunction

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        logic last;
        logic [2:0] k;
        last = cur_step[IBS_LAST_BIT];
        k = cur_step[2:0];
        next_cur = cur;
        next_cur.req = 1'b0;
        next_cur.wr = 1'b0;
        next_cur.byt = 1'b0;
        next_cur.lck = 1'b0;
        next_cur.kind = IBS_K_IDLE;
        next_cur.done = 1'b0;
        next_cur.unsup = 1'b0;
        unique case (cur.st)
            IBS_IDLE: begin
                if (START) begin
                    if (OP == IBS_CLEAR_ACC || OP > IBS_CLEAR_ACC) begin
                        next_cur.unsup = 1'b1; // No bus activity at all
                        next_cur.done = 1'b1;
                    end else begin
                        next_cur.st = IBS_RUN;
                        next_cur.op = OP;
                        next_cur.adv = ADVANCED;
                        next_cur.reps = COUNT;
                        next_cur.idx = 3'd0;
                        next_cur.loop_ph = 1'b0;
                    end
                end
            end
            IBS_RUN: begin
                if (k == IBS_K_LOOP) begin
                    // Repeated pairs; zero count skips straight on
                    if (cur.reps == 8'h00) begin
                        if (last) begin
                            next_cur.st = IBS_IDLE;
                            next_cur.done = 1'b1;
                        end else begin
                            // Issue the following step now, so no empty state appears
                            next_cur.req = 1'b1;
                            next_cur.wr = is_write(after_loop[2:0]);
                            next_cur.byt = is_byte(after_loop[2:0]);
                            next_cur.lck = after_loop[IBS_LOCK_BIT];
                            next_cur.kind = after_loop[2:0];
                            if (after_loop[IBS_LAST_BIT]) begin
                                next_cur.st = IBS_IDLE;
                                next_cur.done = 1'b1;
                            end else begin
                                next_cur.idx = cur.idx + 3'd2;
                            end
                        end
                    end else begin
                        next_cur.req = 1'b1;
                        if (cur.op == IBS_BLOCK_MOVE) begin
                            next_cur.wr = cur.loop_ph;
                            next_cur.byt = 1'b1;
                            next_cur.kind = cur.loop_ph ? IBS_K_WRB : IBS_K_RDB;
                        end else begin
                            next_cur.lck = ~cur.loop_ph; // High word locked
                            next_cur.kind = IBS_K_RDW;
                        end
                        next_cur.loop_ph = ~cur.loop_ph;
                        if (cur.loop_ph) begin
                            next_cur.reps = cur.reps - 8'h01;
                            // Final pair leaves the loop in its own cycle, no gap follows
                            if (cur.reps == 8'h01) begin
                                if (last) begin
                                    next_cur.st = IBS_IDLE;
                                    next_cur.done = 1'b1;
                                end else begin
                                    next_cur.idx = cur.idx + 3'd1;
                                end
                            end
                        end
                    end
                end else if (k == IBS_K_IDLE) begin
                    // Internal state(s): no bus request
                    if (cur.op == IBS_SDIV_BYTE || cur.op == IBS_UDIV_BYTE) begin
                        // This state and the final DONE state both count
                        next_cur.wait_n = IBS_DIV_BYTE_STATES - 5'd2;
                        next_cur.st = IBS_WAIT;
                    end else if (cur.op == IBS_SDIV_WORD || cur.op == IBS_UDIV_WORD) begin
                        next_cur.wait_n = IBS_DIV_WORD_STATES - 5'd2;
                        next_cur.st = IBS_WAIT;
                    end else begin
                        next_cur.idx = cur.idx + 3'd1; // One state
                    end
                end else begin
                    // Typed bus cycle with lock
                    next_cur.req = 1'b1;
                    next_cur.wr = is_write(k);
                    next_cur.byt = is_byte(k);
                    next_cur.lck = cur_step[IBS_LOCK_BIT];
                    next_cur.kind = k;
                    if (last) begin
                        next_cur.st = IBS_IDLE;
                        next_cur.done = 1'b1;
                    end else begin
                        next_cur.idx = cur.idx + 3'd1;
                    end
                end
            end
            IBS_WAIT: begin
                if (cur.wait_n == 5'd0) begin
                    next_cur.st = IBS_IDLE;
                    next_cur.done = 1'b1;
                end else begin
                    next_cur.wait_n = cur.wait_n - 5'd1;
                end
            end
            default: next_cur.st = IBS_IDLE;
        endcase
        // Busy follows the state that is about to be registered
        next_cur.busy = (next_cur.st != IBS_IDLE);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            cur <= '{st: IBS_IDLE, kind: IBS_K_IDLE, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign BUS_REQ = cur.req;
    assign BUS_WRITE = cur.wr;
    assign BUS_BYTE = cur.byt;
    assign BUS_LOCK = cur.lck;
    assign BUS_KIND = cur.kind;
    assign BUSY = cur.busy;
    assign DONE = cur.done;
    assign UNSUPPORTED = cur.unsup;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    a_lock_needs_req: assert property (BUS_LOCK |-> BUS_REQ) else $error("lock without cycle");
    a_unsup_no_bus: assert property (START && !BUSY && OP >= IBS_CLEAR_ACC |=> !BUS_REQ && UNSUPPORTED)
        else $error("unsupported op made bus activity");
    a_udiv_byte_len: assert property (
        START && !BUSY && OP == IBS_UDIV_BYTE |=> ##1 BUS_REQ ##1 !BUS_REQ [*8] ##0 !DONE
        ##1 !BUS_REQ ##1 !BUS_REQ ##1 !BUS_REQ && DONE) else $error("unsigned byte divide length wrong");
    a_sdiv_first: assert property (
        START && !BUSY && OP == IBS_SDIV_WORD |=> ##1 BUS_REQ ##1 BUS_REQ ##1 !BUS_REQ)
        else $error("signed divide fetch count wrong");
    a_test_no_write: assert property (BUSY && cur.op == IBS_BIT_TEST_IND |-> !BUS_WRITE)
        else $error("bit test wrote");
    a_store_rmw: assert property (BUS_LOCK && BUS_BYTE && !BUS_WRITE && cur.op == IBS_BIT_STORE_ABS32
        |=> BUS_LOCK && BUS_KIND == IBS_K_FETCH ##1 BUS_WRITE && BUS_BYTE)
        else $error("bit store rmw order wrong");
    a_jump24_idle: assert property (
        START && !BUSY && OP == IBS_JUMP_ABS24 |=> ##1 BUS_REQ ##1 !BUS_REQ ##1 BUS_REQ)
        else $error("abs24 jump order wrong");
    a_done_idle: assert property (DONE |-> !BUSY) else $error("done while busy");
    c_block_move: cover property (cur.op == IBS_BLOCK_MOVE && BUS_WRITE && BUS_BYTE);
    c_multi_pop: cover property (cur.op == IBS_MULTI_POP && BUS_LOCK && BUS_KIND == IBS_K_RDW);
    c_call_adv: cover property (cur.op == IBS_CALL_MEM_IND && cur.adv && BUS_WRITE);

endmodule

`default_nettype wire

/* verif/ibs_bus_model.sv */
// Model of on-chip memory and peripherals behind the sequencer's bus outputs
// Assumes every request is granted in its own state; logs one entry per state
`timescale 1ns/1ps
`default_nettype none

module ibs_bus_model
    import ibs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Bus cycle from the sequencer
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic bus_byte,
    input wire logic bus_lock,
    input wire logic [2:0] bus_kind,
    // Completion
    input wire logic done
);
    // ****************************************
    // Cycle log
    // ****************************************
    logic [3:0] log_q[$]; // Entries {lock, kind}; idle states as kind 5
    logic in_seq = 1'b0; // Between first cycle and done pulse
    int form_errs = 0; // Cycles whose flags contradict their kind

    // Memory answers at once; a locked cycle keeps the bus for the next one
    always @(posedge clk_sys) begin
        if (!resetn) begin
            in_seq = 1'b0;
        end else begin
            if (bus_req) begin
                in_seq = 1'b1;
                // Write and byte flags must match the kind
                if (bus_write !== (bus_kind == IBS_K_WRB || bus_kind == IBS_K_WRW)) form_errs++;
                if (bus_byte !== (bus_kind == IBS_K_RDB || bus_kind == IBS_K_WRB)) form_errs++;
            end
            if (in_seq) log_q.push_back(bus_req ? {bus_lock, bus_kind} : {1'b0, IBS_K_IDLE});
            if (done) in_seq = 1'b0;
        end
    end
endmodule

`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench: issues each instruction form and compares the logged cycles
// Assumes the sequencer always gets the bus; expectations coded as {lock, kind}
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end

module tb_top;
    import ibs_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0;
    logic [4:0] op = 5'h00;
    logic adv = 1'b0;
    logic [7:0] cnt = 8'h00;
    logic bus_req, bus_write, bus_byte, bus_lock, busy, done, unsup;
    logic [2:0] bus_kind;
    logic [3:0] exp_q[$]; // Expected cycle list
    logic unsup_seen;
    int err_total = 0;
    int samples_checked = 0;

    // 200 MHz core clock
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    ibs_sequencer ibs_sequencer_inst (.CLK_SYS(clk_sys), .RESETN(resetn), .START(start), .OP(op),
        .ADVANCED(adv), .COUNT(cnt), .BUS_REQ(bus_req), .BUS_WRITE(bus_write), .BUS_BYTE(bus_byte),
        .BUS_LOCK(bus_lock), .BUS_KIND(bus_kind), .BUSY(busy), .DONE(done), .UNSUPPORTED(unsup));

    ibs_bus_model ibs_bus_model_inst (.clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req),
        .bus_write(bus_write), .bus_byte(bus_byte), .bus_lock(bus_lock), .bus_kind(bus_kind),
        .done(done));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test();
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Called at a falling edge; holds START for one rising edge
    task automatic issue(input logic [4:0] o, input logic a, input logic [7:0] n);
        start = 1'b1;
        op = o;
        adv = a;
        cnt = n;
        @(negedge clk_sys);
        start = 1'b0;
    endtask

    // Bounded wait for the done pulse, looked at in its own cycle
    task automatic wait_done();
        int i;
        for (i = 0; i < 600; i++) begin
            if (done === 1'b1) break;
            @(negedge clk_sys);
        end
        if (i == 600) begin
            err_total++;
            end_of_test();
        end
        unsup_seen = unsup;
    endtask

    // Compare the logged cycles once the done state has been recorded
    task automatic check_log();
        @(posedge clk_sys);
        #1;
        `CHK(ibs_bus_model_inst.log_q.size(), exp_q.size())
        foreach (exp_q[k]) begin
            if (k < ibs_bus_model_inst.log_q.size()) `CHK(ibs_bus_model_inst.log_q[k], exp_q[k])
        end
        `CHK(ibs_bus_model_inst.form_errs, 0)
        ibs_bus_model_inst.log_q.delete();
    endtask

    task automatic run_op(input logic [4:0] o, input logic a, input logic [7:0] n);
        issue(o, a, n);
        wait_done();
        `CHK(unsup_seen, (o >= 5'h12))
        check_log();
        @(negedge clk_sys);
    endtask

    task automatic add_idle(input int k);
        repeat (k) exp_q.push_back(4'h5);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_bit_ops();
        exp_q = '{4'h0, 4'h0, 4'h0, 4'h9, 4'h8, 4'h3};
        run_op(IBS_BIT_STORE_ABS32, 1'b0, 8'h00);
        exp_q = '{4'h0, 4'h1, 4'h8};
        run_op(IBS_BIT_TEST_IND, 1'b0, 8'h00);
        exp_q = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h8};
        run_op(IBS_BIT_XOR_ABS32, 1'b0, 8'h00);
    endtask

    // Idle states carry no bus request at all
    task automatic t_divides();
        exp_q = '{4'h0, 4'h0};
        add_idle(11);
        run_op(IBS_SDIV_BYTE, 1'b0, 8'h00);
        exp_q = '{4'h0, 4'h0};
        add_idle(19);
        run_op(IBS_SDIV_WORD, 1'b0, 8'h00);
        exp_q = '{4'h0};
        add_idle(11);
        run_op(IBS_UDIV_BYTE, 1'b0, 8'h00);
        exp_q = '{4'h0};
        add_idle(19);
        run_op(IBS_UDIV_WORD, 1'b0, 8'h00);
    endtask

    // Repeat count of three, then the empty boundary
    task automatic t_repeats();
        exp_q = '{4'h0, 4'h1, 4'h1, 4'h1, 4'h3, 4'h1, 4'h3, 4'h1, 4'h3, 4'h0};
        run_op(IBS_BLOCK_MOVE, 1'b0, 8'h03);
        exp_q = '{4'h0, 4'h1, 4'h1, 4'h0};
        run_op(IBS_BLOCK_MOVE, 1'b0, 8'h00);
        exp_q = '{4'h0, 4'h8, 4'h5, 4'ha, 4'h2, 4'ha, 4'h2};
        run_op(IBS_MULTI_POP, 1'b0, 8'h02);
    endtask

    task automatic t_flow();
        exp_q = '{4'h0, 4'h5, 4'h0};
        run_op(IBS_JUMP_ABS24, 1'b0, 8'h00);
        exp_q = '{4'h0, 4'ha, 4'h2, 4'h5, 4'h0};
        run_op(IBS_JUMP_MEM_IND, 1'b1, 8'h00);
        exp_q = '{4'h0, 4'h2, 4'h5, 4'h0};
        run_op(IBS_JUMP_MEM_IND, 1'b0, 8'h00);
        exp_q = '{4'h0, 4'h0, 4'h4};
        run_op(IBS_CALL_REG_IND, 1'b0, 8'h00);
        exp_q = '{4'h0, 4'h0, 4'hc, 4'h4};
        run_op(IBS_CALL_REG_IND, 1'b1, 8'h00);
        exp_q = '{4'h0, 4'ha, 4'h2, 4'hc, 4'h4, 4'h0};
        run_op(IBS_CALL_MEM_IND, 1'b1, 8'h00);
        exp_q = '{4'h0, 4'h2, 4'h4, 4'h0};
        run_op(IBS_CALL_MEM_IND, 1'b0, 8'h00);
        exp_q = '{4'h0, 4'h5, 4'h0, 4'h4};
        run_op(IBS_CALL_REL16, 1'b0, 8'h00);
        exp_q = '{4'h0, 4'h5, 4'h0, 4'hc, 4'h4};
        run_op(IBS_CALL_REL16, 1'b1, 8'h00);
    endtask

    task automatic t_loads_compares();
        exp_q = '{4'h0, 4'h0, 4'h5, 4'h2};
        run_op(IBS_LDCTL_POSTINC, 1'b0, 8'h00);
        exp_q = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
        run_op(IBS_LDCTL_DISP32, 1'b0, 8'h00);
        exp_q = '{4'h0, 4'h0, 4'h0};
        run_op(IBS_CMP_LONG_IMM, 1'b0, 8'h00);
        exp_q = '{4'h0};
        run_op(IBS_CMP_LONG_REG, 1'b0, 8'h00);
    endtask

    // Rejected codes end with no bus activity
    task automatic t_unsupported();
        exp_q.delete();
        run_op(IBS_CLEAR_ACC, 1'b0, 8'h00);
        run_op(5'h1f, 1'b0, 8'h00);
    endtask

    // A start while busy is ignored; a start in the done cycle chains at once
    task automatic t_busy_and_chain();
        exp_q = '{4'h0, 4'h5, 4'h0};
        issue(IBS_JUMP_ABS24, 1'b0, 8'h00);
        @(negedge clk_sys);
        start = 1'b1;
        op = IBS_CMP_LONG_IMM;
        @(negedge clk_sys);
        start = 1'b0;
        wait_done();
        check_log();
        repeat (6) @(negedge clk_sys);
        `CHK(ibs_bus_model_inst.log_q.size(), 0)
        exp_q = '{4'h0, 4'h5, 4'h0, 4'h0};
        issue(IBS_JUMP_ABS24, 1'b0, 8'h00);
        wait_done();
        issue(IBS_CMP_LONG_REG, 1'b0, 8'h00);
        wait_done();
        check_log();
        @(negedge clk_sys);
    endtask

    // Reset in mid-sequence clears everything; a fresh jump then runs clean
    task automatic t_mid_reset();
        issue(IBS_BLOCK_MOVE, 1'b0, 8'h0a);
        repeat (4) @(negedge clk_sys);
        resetn = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK({busy, bus_req, done}, 3'h0)
        resetn = 1'b1;
        ibs_bus_model_inst.log_q.delete();
        @(negedge clk_sys);
        exp_q = '{4'h0, 4'h5, 4'h0};
        run_op(IBS_JUMP_ABS24, 1'b0, 8'h00);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (10) @(negedge clk_sys);
        resetn = 1'b1;
        @(negedge clk_sys);
        t_bit_ops();
        t_divides();
        t_repeats();
        t_flow();
        t_loads_compares();
        t_unsupported();
        t_busy_and_chain();
        t_mid_reset();
        end_of_test();
    end
endmodule

`default_nettype wire
